// *** rtl/prtm_core.sv ***
// periodic timer: compare, timer/counter, pwm, single pulse, capture
module prtm_core
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // configuration
    input wire prtm_pkg::prtm_cfg_t i_cfg,
    input wire prtm_pkg::prtm_cmp_t i_cmp,
    // software control
    input wire logic i_run_set,
    input wire logic i_run_clear,
    input wire logic i_compare_a_flag_clear,
    input wire logic i_compare_p_flag_clear,
    // timer clock enable and pins
    input wire logic i_timer_tick,
    input wire logic i_external_clock_pin,
    input wire logic i_capture_input_pin,
    // status
    output logic o_run_bit,
    output logic [9:0] o_counter,
    output logic [9:0] o_capture_a,
    output logic [9:0] o_capture_b,
    output logic o_compare_a_flag,
    output logic o_compare_p_flag,
    output logic o_latch_edge_flag,
    // output pin
    output logic o_timer_out,
    output logic o_timer_out_oe_n
);
    import prtm_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic run;
        logic run_prev;
        logic [9:0] cnt;
        logic raw;
        logic pin;
        logic oe_n;
        logic flag_a;
        logic flag_p;
        logic [9:0] cap_a;
        logic [9:0] cap_b;
        logic latch_edge;
        logic src_prev;
        logic ext_prev;
    } prtm_state_t;

    prtm_state_t state_reg;
    prtm_state_t state_next;

    // active-edge decode shared by capture and clear selection
    function automatic logic edge_match(input logic [1:0] sel, input logic rise,
                                        input logic fall);
        logic hit;
        hit = 1'b0;
        case (sel)
            FN_00: hit = rise;
            FN_01: hit = fall;
            FN_10: hit = rise | fall;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : edge_match

    // ****************************************
    // decode
    // ****************************************
    logic [9:0] cnt_inc;
    logic [9:0] cmp_a;
    logic [9:0] cmp_p;
    logic [10:0] period_ext;
    logic run_rise;
    logic running;
    logic a_hit;
    logic p_hit;
    logic sel_pwm;
    logic sel_single;
    logic sel_capture;
    logic sel_compare;
    logic duty_full;
    logic act_lvl;
    logic src_now;
    logic src_rise;
    logic src_fall;
    logic ext_rise;
    logic cap_edge;
    logic cap_clear;
    logic set_a;
    logic set_p;

    always_comb
    begin
        cmp_a = i_cmp.compare_a_value;
        cmp_p = i_cmp.period_compare_value;
        cnt_inc = state_reg.cnt + 10'h001;
        run_rise = state_reg.run & ~state_reg.run_prev;
        running = state_reg.run & i_timer_tick;
        // next count equal to compare: period 0 hits at the 3FF wrap
        a_hit = running & (cnt_inc == cmp_a);
        p_hit = running & (cnt_inc == cmp_p);
        sel_pwm = (i_cfg.mode == MODE_PWM) & (i_cfg.output_function != FN_11);
        sel_single = (i_cfg.mode == MODE_PWM) & (i_cfg.output_function == FN_11);
        sel_capture = (i_cfg.mode == MODE_CAPTURE);
        sel_compare = (i_cfg.mode == MODE_COMPARE) | (i_cfg.mode == MODE_TIMER);
        period_ext = (cmp_p == CNT_ZERO) ? FULL_PERIOD : {1'b0, cmp_p};
        duty_full = ({1'b0, cmp_a} >= period_ext);
        act_lvl = i_cfg.output_initial_level;
        src_now = i_cfg.capture_source_select ? i_external_clock_pin
                                              : i_capture_input_pin;
        // single-cycle sampling: very short pulses can slip past
        src_rise = src_now & ~state_reg.src_prev;
        src_fall = ~src_now & state_reg.src_prev;
        ext_rise = i_external_clock_pin & ~state_reg.ext_prev;
        cap_edge = edge_match(i_cfg.output_function, src_rise, src_fall);
        cap_clear = state_reg.run &
                    edge_match(i_cfg.capture_clear_select - 2'b01, src_rise, src_fall) &
                    (i_cfg.capture_clear_select != FN_00);
        // flag set events, so that a clear in the same cycle loses
        set_a = sel_pwm ? a_hit : sel_capture ? cap_edge :
                (a_hit & ~run_rise & (sel_single | (cmp_a != CNT_ZERO)));
        set_p = p_hit & ~sel_single & ~(sel_compare & (i_cfg.counter_clear_select | run_rise));
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        state_next.src_prev = src_now;
        state_next.ext_prev = i_external_clock_pin;
        state_next.run_prev = state_reg.run;

        // run control: software set/clear, external pin start in single pulse
        if (i_run_set)
        begin
            state_next.run = 1'b1;
        end
        else if (i_run_clear)
        begin
            state_next.run = 1'b0;
        end
        if (sel_single && ext_rise)
        begin
            state_next.run = 1'b1;
        end

        // counter: held while stopped, zeroed on a run rise
        if (run_rise)
        begin
            state_next.cnt = CNT_RST;
        end
        else if (running)
        begin
            state_next.cnt = cnt_inc;
        end

        // output pin drive
        state_next.oe_n = ~(sel_pwm | sel_single | (i_cfg.mode == MODE_COMPARE));

        if (sel_compare)
        begin
            if (i_cfg.counter_clear_select)
            begin
                if (a_hit && !run_rise)
                begin
                    state_next.cnt = CNT_RST;
                end
            end
            else if (p_hit && !run_rise)
            begin
                state_next.cnt = CNT_RST;
                state_next.flag_p = 1'b1;
            end
            if (run_rise)
            begin
                state_next.raw = act_lvl;
            end
            else if (a_hit && cmp_a != CNT_ZERO)
            begin
                state_next.flag_a = 1'b1;
                case (i_cfg.output_function)
                    FN_01: state_next.raw = 1'b0;
                    FN_10: state_next.raw = 1'b1;
                    FN_11: state_next.raw = ~state_reg.raw;
                    default: state_next.raw = state_reg.raw;
                endcase
            end
        end
        else if (sel_pwm)
        begin
            // counting goes on whatever the output function
            if (p_hit && !run_rise)
            begin
                state_next.cnt = CNT_RST;
            end
            state_next.flag_a = state_reg.flag_a | a_hit;
            state_next.flag_p = state_reg.flag_p | p_hit;
            case (i_cfg.output_function)
                FN_00: state_next.raw = ~act_lvl;
                FN_01: state_next.raw = act_lvl;
                default: state_next.raw = (duty_full || state_next.cnt < cmp_a) ?
                                          act_lvl : ~act_lvl;
            endcase
        end
        else if (sel_single)
        begin
            if (a_hit && !run_rise)
            begin
                state_next.run = 1'b0;
                state_next.flag_a = 1'b1;
            end
            state_next.raw = state_next.run ? act_lvl : ~act_lvl;
        end
        else
        begin
            // capture: free-runs, cleared by period match or pin edge
            if ((p_hit || cap_clear) && !run_rise)
            begin
                state_next.cnt = CNT_RST;
            end
            state_next.flag_p = state_reg.flag_p | p_hit;
            if (cap_edge)
            begin
                state_next.flag_a = 1'b1;
                state_next.latch_edge = src_rise;
                if (i_cfg.capture_clear_select == FN_00 || src_rise)
                begin
                    state_next.cap_a = state_reg.cnt;
                end
                else
                begin
                    state_next.cap_b = state_reg.cnt;
                end
            end
        end

        state_next.pin = state_next.oe_n ? 1'b0 : state_next.raw ^ i_cfg.output_invert;

        // flag clears lose to a set arriving in the same cycle
        if (i_compare_a_flag_clear && !set_a)
        begin
            state_next.flag_a = 1'b0;
        end
        if (i_compare_p_flag_clear && !set_p)
        begin
            state_next.flag_p = 1'b0;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_reg <= '{run: 1'b0, run_prev: 1'b0, cnt: CNT_RST, raw: 1'b0,
                           pin: 1'b0, oe_n: 1'b1, flag_a: 1'b0, flag_p: 1'b0,
                           cap_a: CNT_RST, cap_b: CNT_RST, latch_edge: 1'b0,
                           src_prev: 1'b0, ext_prev: 1'b0};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    always_comb
    begin
        o_run_bit = state_reg.run;
        o_counter = state_reg.cnt;
        o_capture_a = state_reg.cap_a;
        o_capture_b = state_reg.cap_b;
        o_compare_a_flag = state_reg.flag_a;
        o_compare_p_flag = state_reg.flag_p;
        o_latch_edge_flag = state_reg.latch_edge;
        o_timer_out = state_reg.pin;
        o_timer_out_oe_n = state_reg.oe_n;
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_reset_n);

    timer_no_drive_a: assert property (
        (i_cfg.mode == MODE_TIMER) |=> o_timer_out_oe_n)
        else $error("timer/counter mode drives the pin");

    pwm_period_clear_a: assert property (
        sel_pwm && p_hit && !run_rise |=> o_counter == CNT_ZERO && o_compare_p_flag)
        else $error("pwm period match did not clear counter");

    pwm_full_duty_a: assert property (
        sel_pwm && i_cfg.output_function == FN_10 && duty_full
        |=> o_timer_out == $past(act_lvl ^ i_cfg.output_invert))
        else $error("pwm full duty not at active level");

    duty_flag_a: assert property (
        sel_pwm && a_hit |=> o_compare_a_flag)
        else $error("duty match did not set flag A");

    forced_count_a: assert property (
        sel_pwm && i_cfg.output_function == FN_00 && running && !p_hit && !run_rise
        |=> o_counter == $past(cnt_inc))
        else $error("counter stalled while pwm forced");

    ext_start_a: assert property (
        sel_single && ext_rise && !o_run_bit |=> o_run_bit ##1 o_counter == CNT_ZERO)
        else $error("external edge did not start pulse");

    pulse_end_a: assert property (
        sel_single && a_hit && !run_rise && !i_run_set && !ext_rise
        |=> !o_run_bit && o_compare_a_flag)
        else $error("compare A did not end pulse");

    capture_latch_a: assert property (
        sel_capture && cap_edge && i_cfg.capture_clear_select == FN_00
        |=> o_capture_a == $past(o_counter) && o_compare_a_flag)
        else $error("capture did not latch counter");

    capture_none_a: assert property (
        sel_capture && i_cfg.output_function == FN_11
        |=> $stable(o_capture_a) && $stable(o_capture_b))
        else $error("capture happened with edge selector 11");

    edge_flag_a: assert property (
        sel_capture && cap_edge |=> o_latch_edge_flag == $past(src_rise))
        else $error("latch edge flag wrong");

    stopped_hold_a: assert property (
        !o_run_bit |=> $stable(o_counter))
        else $error("stopped counter moved");

endmodule : prtm_core

// *** rtl/prtm_pkg.sv ***
// shared types and constants of the periodic timer with modes
package prtm_pkg;

    // ****************************************
    // widths and reset values
    // ****************************************
    localparam int CNT_W = 10;
    localparam logic [9:0] CNT_RST = 10'h000;
    localparam logic [9:0] CNT_ZERO = 10'h000;
    localparam logic [10:0] FULL_PERIOD = 11'h400;

    // ****************************************
    // timing
    // ****************************************
    localparam int CORE_CLK_PERIOD_NS = 4;
    localparam int TIMER_CLK_MAX_MHZ = 50;
    localparam int TIMER_CLK_MIN_PERIOD_NS = 1000 / TIMER_CLK_MAX_MHZ;
    // least spacing of timer ticks, rounded up to whole core cycles
    localparam int TICK_MIN_CYCLES =
        (TIMER_CLK_MIN_PERIOD_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;

    // ****************************************
    // modes and selectors
    // ****************************************
    typedef enum logic [1:0] {
        MODE_COMPARE = 2'b00,
        MODE_CAPTURE = 2'b01,
        MODE_PWM = 2'b10,
        MODE_TIMER = 2'b11
    } prtm_mode_t;

    localparam logic [1:0] FN_00 = 2'b00;
    localparam logic [1:0] FN_01 = 2'b01;
    localparam logic [1:0] FN_10 = 2'b10;
    localparam logic [1:0] FN_11 = 2'b11;

    typedef struct packed {
        prtm_mode_t mode;
        logic [1:0] output_function;
        logic counter_clear_select;
        logic output_initial_level;
        logic output_invert;
        logic capture_source_select;
        logic [1:0] capture_clear_select;
    } prtm_cfg_t;

    typedef struct packed {
        logic [9:0] compare_a_value;
        logic [9:0] period_compare_value;
    } prtm_cmp_t;

endpackage : prtm_pkg

// *** testbench/prtm_tb.sv ***
// self-checking bench for the periodic timer with modes
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import prtm_pkg::*;
    // ****************************************
    // stimulus, observation, bookkeeping
    // ****************************************
    logic i_core_clk = 1'b0;
    logic i_reset_n = 1'b0;
    prtm_cfg_t cfg = '0;
    prtm_cmp_t cmp = '0;
    logic run_set = 1'b0;
    logic run_clr = 1'b0;
    logic a_clr = 1'b0;
    logic p_clr = 1'b0;
    logic tick = 1'b0;
    logic ext_pin = 1'b0;
    logic cap_pin = 1'b0;
    logic [2:0] tick_cnt = 3'h0;
    logic run_bit, flag_a, flag_p, edge_flag, t_out, t_oe_n;
    logic [9:0] cnt, cap_a, cap_b;
    int failures = 0;
    int comparisons = 0;

    prtm_core dut
    (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_cfg(cfg),
        .i_cmp(cmp),
        .i_run_set(run_set),
        .i_run_clear(run_clr),
        .i_compare_a_flag_clear(a_clr),
        .i_compare_p_flag_clear(p_clr),
        .i_timer_tick(tick),
        .i_external_clock_pin(ext_pin),
        .i_capture_input_pin(cap_pin),
        .o_run_bit(run_bit),
        .o_counter(cnt),
        .o_capture_a(cap_a),
        .o_capture_b(cap_b),
        .o_compare_a_flag(flag_a),
        .o_compare_p_flag(flag_p),
        .o_latch_edge_flag(edge_flag),
        .o_timer_out(t_out),
        .o_timer_out_oe_n(t_oe_n)
    );

    initial
        forever #2 i_core_clk = ~i_core_clk;

    // one tick in five cycles: the fastest rate the counter accepts
    always @(posedge i_core_clk)
    begin
        tick_cnt <= (tick_cnt == 3'h4) ? 3'h0 : tick_cnt + 3'h1;
        tick <= (tick_cnt == 3'h4);
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk_val(input logic [9:0] got, input logic [9:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: value %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    // outputs are read 1 ns after the edge so they have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask : cyc

    task automatic run_pulse(input logic on);
        @(posedge i_core_clk);
        run_set <= on;
        run_clr <= ~on;
        @(posedge i_core_clk);
        run_set <= 1'b0;
        run_clr <= 1'b0;
    endtask : run_pulse

    task automatic clr_flags;
        @(posedge i_core_clk);
        a_clr <= 1'b1;
        p_clr <= 1'b1;
        @(posedge i_core_clk);
        a_clr <= 1'b0;
        p_clr <= 1'b0;
    endtask : clr_flags

    task automatic wait_cnt(input logic [9:0] v, input int lim);
        int i;
        #1;
        for (i = 0; i < lim && cnt !== v; i++)
            cyc(1);
        chk_val(cnt, v);
    endtask : wait_cnt

    // ****************************************
    // scenarios
    // ****************************************
    task automatic pwm_shape(input logic ini, input logic inv, input logic [1:0] fn,
        input logic [9:0] duty);
        logic act;
        logic want;
        logic [9:0] top;
        act = ini ^ inv;
        top = 10'h000;
        @(posedge i_core_clk);
        cfg <= '{MODE_PWM, fn, 1'b1, ini, inv, 1'b0, 2'b00};
        cmp <= '{duty, 10'h004};
        clr_flags;
        run_pulse(1'b1);
        cyc(30);
        repeat (40)
        begin
            cyc(1);
            if (cnt > top)
                top = cnt;
            want = fn[0] ? act : ~act;
            if (fn == FN_10)
                want = (cnt < duty) ? act : ~act;
            chk_bit(t_out, want);
            chk_bit(t_oe_n, 1'b0);
        end
        chk_val(top, 10'h003);
        chk_bit(flag_p, 1'b1);
        if (duty < 10'h004)
            chk_bit(flag_a, 1'b1);
        run_pulse(1'b0);
    endtask : pwm_shape

    task automatic full_period;
        @(posedge i_core_clk);
        cfg <= '{MODE_PWM, FN_10, 1'b0, 1'b1, 1'b0, 1'b0, 2'b00};
        cmp <= '{10'h200, 10'h000};
        clr_flags;
        run_pulse(1'b1);
        wait_cnt(10'h3FF, 6000);
        chk_bit(flag_p, 1'b0);
        wait_cnt(10'h000, 10);
        chk_bit(flag_p, 1'b1);
        run_pulse(1'b0);
    endtask : full_period

    task automatic timer_mode(input prtm_mode_t md, input logic ccs);
        logic [9:0] top;
        top = 10'h000;
        @(posedge i_core_clk);
        cfg <= '{md, FN_10, ccs, 1'b1, 1'b0, 1'b0, 2'b00};
        cmp <= '{10'h002, 10'h006};
        clr_flags;
        run_pulse(1'b1);
        repeat (80)
        begin
            cyc(1);
            if (cnt > top)
                top = cnt;
            chk_bit(t_oe_n, md == MODE_TIMER);
        end
        chk_val(top, ccs ? 10'h001 : 10'h005);
        chk_bit(flag_a, 1'b1);
        chk_bit(flag_p, ~ccs);
        run_pulse(1'b0);
    endtask : timer_mode

    task automatic single_pulse;
        logic [9:0] hold;
        int i;
        @(posedge i_core_clk);
        cfg <= '{MODE_PWM, FN_11, 1'b0, 1'b1, 1'b0, 1'b0, 2'b00};
        cmp <= '{10'h003, 10'h001};
        clr_flags;
        @(posedge i_core_clk);
        ext_pin <= 1'b1;
        cyc(3);
        chk_bit(run_bit, 1'b1);
        chk_bit(t_out, 1'b1);
        for (i = 0; i < 40 && run_bit === 1'b1; i++)
            cyc(1);
        chk_bit(run_bit, 1'b0);
        chk_bit(flag_a, 1'b1);
        chk_bit(t_out, 1'b0);
        hold = cnt;
        @(posedge i_core_clk);
        ext_pin <= 1'b0;
        cyc(20);
        chk_val(cnt, hold);
        run_pulse(1'b1);
        cyc(1);
        chk_val(cnt, 10'h000);
        chk_bit(t_out, 1'b1);
        run_pulse(1'b0);
        cyc(2);
        chk_bit(t_out, 1'b0);
    endtask : single_pulse

    // drive the selected pin, then judge capture, flag and clear one cycle on
    task automatic cap_edge(input logic lvl, input logic cap, input logic clr);
        logic [9:0] exp;
        @(posedge i_core_clk);
        if (cfg.capture_source_select)
            ext_pin <= lvl;
        else
            cap_pin <= lvl;
        #1;
        exp = cnt;
        cyc(1);
        if (cap && (cfg.capture_clear_select == 2'b00 || lvl))
            chk_val(cap_a, exp);
        else if (cap)
            chk_val(cap_b, exp);
        if (cap && cfg.capture_clear_select != 2'b00)
            chk_bit(edge_flag, lvl);
        chk_bit(flag_a, cap);
        if (clr)
            chk_bit(cnt < 10'h002, 1'b1);
        clr_flags;
        cyc(12);
    endtask : cap_edge

    task automatic capture;
        logic [9:0] hold;
        @(posedge i_core_clk);
        cfg <= '{MODE_CAPTURE, FN_00, 1'b0, 1'b0, 1'b0, 1'b0, 2'b00};
        cmp <= '{10'h000, 10'h000};
        clr_flags;
        run_pulse(1'b1);
        cyc(20);
        cap_edge(1'b1, 1'b1, 1'b0);
        cap_edge(1'b0, 1'b0, 1'b0);
        @(posedge i_core_clk);
        cfg.output_function <= FN_01;
        cfg.capture_clear_select <= 2'b01;
        cap_edge(1'b1, 1'b0, 1'b1);
        cap_edge(1'b0, 1'b1, 1'b0);
        @(posedge i_core_clk);
        cfg.output_function <= FN_10;
        cfg.capture_clear_select <= 2'b11;
        cfg.capture_source_select <= 1'b1;
        cap_edge(1'b1, 1'b1, 1'b1);
        cap_edge(1'b0, 1'b1, 1'b1);
        @(posedge i_core_clk);
        cfg.output_function <= FN_11;
        // no pin-edge clears, so the count visibly keeps running
        cfg.capture_clear_select <= 2'b00;
        cap_edge(1'b1, 1'b0, 1'b0);
        hold = cnt;
        cap_edge(1'b0, 1'b0, 1'b0);
        chk_bit(cnt != hold, 1'b1);
        @(posedge i_core_clk);
        cmp.period_compare_value <= 10'h005;
        run_pulse(1'b0);
        run_pulse(1'b1);
        wait_cnt(10'h004, 60);
        wait_cnt(10'h000, 10);
        chk_bit(flag_p, 1'b1);
        run_pulse(1'b0);
    endtask : capture

    task automatic wrap_up;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    // ****************************************
    // sequence and watchdog
    // ****************************************
    initial
    begin
        repeat (12) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
    end

    initial
    begin
        cyc(6);
        chk_val(cnt, 10'h000);
        chk_bit(t_oe_n, 1'b1);
        chk_bit(run_bit, 1'b0);
        cyc(8);
        pwm_shape(1'b1, 1'b0, FN_10, 10'h001);
        pwm_shape(1'b0, 1'b1, FN_10, 10'h002);
        pwm_shape(1'b1, 1'b0, FN_10, 10'h005);
        pwm_shape(1'b1, 1'b1, FN_00, 10'h002);
        pwm_shape(1'b0, 1'b0, FN_01, 10'h002);
        full_period;
        timer_mode(MODE_TIMER, 1'b0);
        timer_mode(MODE_TIMER, 1'b1);
        timer_mode(MODE_COMPARE, 1'b0);
        single_pulse;
        capture;
        wrap_up;
    end

    // whole run needs about 6000 cycles; allow several times that
    initial
    begin
        #150000;
        failures++;
        wrap_up;
    end
endmodule : tb
